//--- dcr_pkg.sv
// Constants, field positions and carrier types for the DAC configuration group
package dcr_pkg;
    // Register addresses on the direct register port
    localparam logic [7:0]  DCR_ADDR_DEVICE_MODE  = 8'h25;
    localparam logic [7:0]  DCR_ADDR_INTERFACE    = 8'h26;
    localparam logic [7:0]  DCR_ADDR_SRAM_POINTER = 8'h2b;
    localparam logic [7:0]  DCR_ADDR_SRAM_WORD    = 8'h2c;
    localparam logic [7:0]  DCR_ADDR_BROADCAST    = 8'h50;
    // PMBus page and command codes
    localparam logic [7:0]  DCR_PM_PAGE_CFG       = 8'hff;
    localparam logic [7:0]  DCR_PM_CMD_PAGE       = 8'h00;
    localparam logic [7:0]  DCR_PM_CMD_DEVICE     = 8'he9;
    localparam logic [7:0]  DCR_PM_CMD_SRAM_PTR   = 8'hef;
    localparam logic [7:0]  DCR_PM_CMD_SRAM_WORD  = 8'hf0;
    localparam logic [7:0]  DCR_PM_CMD_BROADCAST  = 8'hf1;
    // Reset values
    localparam logic [15:0] DCR_RST_DEVICE_MODE   = 16'h0000;
    localparam logic [15:0] DCR_RST_INTERFACE     = 16'h0000;
    localparam logic [7:0]  DCR_RST_SRAM_POINTER  = 8'h00;
    localparam logic [15:0] DCR_RST_BROADCAST     = 16'h0000;
    localparam logic [15:0] DCR_RST_PAGE          = 16'h0300;
    // Writable bits per register; the rest read as zero
    localparam logic [15:0] DCR_MASK_DEVICE_MODE  = 16'hffe0;
    localparam logic [15:0] DCR_MASK_INTERFACE    = 16'h1105;
    localparam logic [15:0] DCR_MASK_SRAM_POINTER = 16'h00ff;
    localparam logic [15:0] DCR_MASK_PAGE         = 16'hff00;
    // Field positions
    localparam int          DCR_BIT_MODE_IN_DIS   = 13;
    localparam int          DCR_POS_PROTECT       = 8;
    localparam int          DCR_BIT_PMBUS_EN      = 8;
    localparam int          DCR_BIT_SERIAL_OUT    = 0;
    localparam int          DCR_POS_CODE_TOP      = 15;
    localparam int          DCR_CHANNELS          = 2;
    localparam int          DCR_SRAM_WORDS        = 256;
    // Broadcast code width: 12 or 10 bits, left-aligned
    localparam int          DCR_CODE_BITS         = 12;
    localparam logic [15:0] DCR_MASK_BROADCAST    =
        16'hffff << (16 - DCR_CODE_BITS);
    // General-purpose pin input setting that selects the protect input
    localparam logic [3:0]  DCR_GPI_PROTECT       = 4'h5;

    // Protect action encodings
    typedef enum logic [1:0] {
        DCR_ACT_HIZ  = 2'h0,
        DCR_ACT_NVM  = 2'h1,
        DCR_ACT_LOW  = 2'h2,
        DCR_ACT_HIGH = 2'h3
    } dcr_action_t;

    // Access request carried on both the direct and the PMBus port
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [15:0] data;
    } dcr_req_t;
endpackage

//--- dcr_config_regs.sv
// Device mode, interface, scratch memory, broadcast and page registers
// Summary of operation
// - Bit 13 of the device mode register puts the device in low power.
// - Protect: 00 Hi-Z; 01 NVM code, 10 slew low, 11 slew high, then Hi-Z.
// - A protect pin falling edge starts the action; a high level is ignored.
// - PMBus accesses are accepted only while interface bit 8 is set.
// - Interface bit 0 enables serial readback on the general-purpose pin.
// - The pointer's low eight bits select the word for the next data access.
// - Each write through the data register advances the pointer by one.
// - A data write stores at the pointer and a data read returns that word.
// - One broadcast code for all channels sits left-aligned in bits 15 to 4.
// - The code is 12 bits wide, or 10 bits followed by two ignored bits.
// - Only channels with their broadcast enable set take a broadcast code.
// - On PMBus page FFh, command EFh is the pointer and F0h the data word.
// - Over PMBus, page FFh command F1h is the broadcast register.
// - Page register: command 00h on any page, reset value 0300h.
module dcr_config_regs
    import dcr_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Direct register port
    input  wire dcr_req_t                  hostReq,
    // PMBus command port, addr carries the command code
    input  wire dcr_req_t                  pmbusReq,
    // Access answer
    output logic                           respValid,
    output logic                           respError,
    output logic [15:0]                    respData,
    // General-purpose pin and its input setting
    input  wire logic                      gpioIn,
    input  wire logic                      gpioInputEnable,
    input  wire logic [3:0]                gpioInputConfig,
    // Channel side
    input  wire logic [DCR_CHANNELS-1:0]   channelBroadcastEnable,
    input  wire logic                      slewDone,
    input  wire logic                      protectClear,
    output logic [DCR_CHANNELS-1:0]        channelCodeLoad,
    output logic [DCR_CODE_BITS-1:0]       allChannelCodeValue,
    output dcr_action_t                    protectCodeSelect,
    output logic                           protectSlewActive,
    output logic                           protectHiz,
    // Configuration levels
    output logic                           lowPowerMode,
    output logic                           pmbusEnable,
    output logic                           serialReadoutEnable
);
    typedef enum {PR_IDLE, PR_JUMP, PR_SLEW, PR_HIZ} dcr_prot_t;

    // Clears the bits that the register does not hold
    function automatic logic [15:0] keep(input logic [15:0] v,
                                         input logic [15:0] m);
        return v & m;
    endfunction

    logic [15:0]           devMode_q,   devMode_d;
    logic [15:0]           ifCfg_q,     ifCfg_d;
    logic [7:0]            sramPtr_q,   sramPtr_d;
    logic [15:0]           bcast_q,     bcast_d;
    logic [15:0]           page_q,      page_d;
    logic [15:0]           sram_q [DCR_SRAM_WORDS];
    logic [15:0]           sram_d [DCR_SRAM_WORDS];
    logic                  respValid_q, respValid_d;
    logic                  respError_q, respError_d;
    logic [15:0]           respData_q,  respData_d;
    logic [DCR_CHANNELS-1:0] load_q,    load_d;
    dcr_req_t              req;
    logic                  mapped;
    logic                  refused;

    // Direct port wins; a PMBus access in the same cycle is dropped without an answer
    always_comb begin
        req     = hostReq;
        mapped  = 1'b1;
        refused = 1'b0;
        if (!(hostReq.write || hostReq.read) &&
            (pmbusReq.write || pmbusReq.read)) begin
            req = pmbusReq;
            if (!ifCfg_q[DCR_BIT_PMBUS_EN]) begin
                refused = 1'b1;
            end else if (pmbusReq.addr == DCR_PM_CMD_PAGE) begin
                req.addr = DCR_PM_CMD_PAGE;
            end else if (page_q[15:8] != DCR_PM_PAGE_CFG) begin
                mapped = 1'b0;
            end else begin
                case (pmbusReq.addr)
                    DCR_PM_CMD_DEVICE:    req.addr = DCR_ADDR_DEVICE_MODE;
                    DCR_PM_CMD_SRAM_PTR:  req.addr = DCR_ADDR_SRAM_POINTER;
                    DCR_PM_CMD_SRAM_WORD: req.addr = DCR_ADDR_SRAM_WORD;
                    DCR_PM_CMD_BROADCAST: req.addr = DCR_ADDR_BROADCAST;
                    default:              mapped   = 1'b0;
                endcase
            end
        end else if (hostReq.addr == DCR_PM_CMD_PAGE) begin
            // Page register has no direct address
            mapped = 1'b0;
        end
    end

    always_comb begin
        devMode_d   = devMode_q;
        ifCfg_d     = ifCfg_q;
        sramPtr_d   = sramPtr_q;
        bcast_d     = bcast_q;
        page_d      = page_q;
        sram_d      = sram_q;
        respValid_d = req.write || req.read;
        respError_d = (req.write || req.read) && (refused || !mapped);
        respData_d  = 16'h0000;
        load_d      = '0;
        if ((req.write || req.read) && !refused && mapped) begin
            case (req.addr)
                DCR_ADDR_DEVICE_MODE: begin
                    if (req.write) begin
                        devMode_d = keep(req.data, DCR_MASK_DEVICE_MODE);
                    end
                    respData_d = devMode_q;
                end
                DCR_ADDR_INTERFACE: begin
                    if (req.write) begin
                        ifCfg_d = keep(req.data, DCR_MASK_INTERFACE);
                    end
                    respData_d = ifCfg_q;
                end
                DCR_ADDR_SRAM_POINTER: begin
                    if (req.write) begin
                        sramPtr_d = req.data[7:0];
                    end
                    respData_d = {8'h00, sramPtr_q};
                end
                DCR_ADDR_SRAM_WORD: begin
                    if (req.write) begin
                        sram_d[sramPtr_q] = req.data;
                        // Eight-bit pointer rolls over on its own
                        sramPtr_d = sramPtr_q + 8'h01;
                    end
                    respData_d = sram_q[sramPtr_q];
                end
                DCR_ADDR_BROADCAST: begin
                    if (req.write) begin
                        bcast_d = keep(req.data, DCR_MASK_BROADCAST);
                        load_d  = channelBroadcastEnable;
                    end
                    respData_d = bcast_q;
                end
                DCR_PM_CMD_PAGE: begin
                    if (req.write) begin
                        page_d = keep(req.data, DCR_MASK_PAGE);
                    end
                    respData_d = page_q;
                end
                default: begin
                    respError_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            devMode_q   <= DCR_RST_DEVICE_MODE;
            ifCfg_q     <= DCR_RST_INTERFACE;
            sramPtr_q   <= DCR_RST_SRAM_POINTER;
            bcast_q     <= DCR_RST_BROADCAST;
            page_q      <= DCR_RST_PAGE;
            respValid_q <= 1'b0;
            respError_q <= 1'b0;
            respData_q  <= 16'h0000;
            load_q      <= '0;
        end else begin
            devMode_q   <= devMode_d;
            ifCfg_q     <= ifCfg_d;
            sramPtr_q   <= sramPtr_d;
            bcast_q     <= bcast_d;
            page_q      <= page_d;
            respValid_q <= respValid_d;
            respError_q <= respError_d;
            respData_q  <= respData_d;
            load_q      <= load_d;
        end
    end

    // Memory contents are not cleared by reset, as in a real array
    always_ff @(posedge clk) begin
        sram_q <= sram_d;
    end

    assign respValid           = respValid_q;
    assign respError           = respError_q;
    assign respData            = respData_q;
    assign channelCodeLoad     = load_q;
    assign allChannelCodeValue =
        bcast_q[DCR_POS_CODE_TOP -: DCR_CODE_BITS];
    assign lowPowerMode        = devMode_q[DCR_BIT_MODE_IN_DIS];
    assign pmbusEnable         = ifCfg_q[DCR_BIT_PMBUS_EN];
    assign serialReadoutEnable = ifCfg_q[DCR_BIT_SERIAL_OUT];

    // Protect sequencer
    dcr_prot_t   prot_q,   prot_d;
    dcr_action_t sel_q,    sel_d;
    logic        slew_q,   slew_d;
    logic        hiz_q,    hiz_d;
    logic        gpioPrev_q;
    logic        protectFall;
    dcr_action_t action;

    assign action      = dcr_action_t'(devMode_q[DCR_POS_PROTECT +: 2]);
    // Only a falling edge counts; a steady high level is ignored
    assign protectFall = gpioInputEnable &&
                         gpioInputConfig == DCR_GPI_PROTECT &&
                         gpioPrev_q && !gpioIn;

    always_comb begin
        prot_d = prot_q;
        sel_d  = sel_q;
        case (prot_q)
            PR_IDLE: begin
                if (protectFall) begin
                    sel_d = action;
                    case (action)
                        DCR_ACT_HIZ: prot_d = PR_HIZ;
                        DCR_ACT_NVM: prot_d = PR_JUMP;
                        default:     prot_d = PR_SLEW;
                    endcase
                end
            end
            PR_JUMP: prot_d = PR_HIZ;
            PR_SLEW: begin
                if (slewDone) begin
                    prot_d = PR_HIZ;
                end
            end
            PR_HIZ: begin
                if (protectClear) begin
                    prot_d = PR_IDLE;
                    sel_d  = DCR_ACT_HIZ;
                end
            end
            default: prot_d = PR_IDLE;
        endcase
        slew_d = prot_d == PR_SLEW;
        hiz_d  = prot_d == PR_HIZ;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prot_q     <= PR_IDLE;
            sel_q      <= DCR_ACT_HIZ;
            slew_q     <= 1'b0;
            hiz_q      <= 1'b0;
            gpioPrev_q <= 1'b1;
        end else begin
            prot_q     <= prot_d;
            sel_q      <= sel_d;
            slew_q     <= slew_d;
            hiz_q      <= hiz_d;
            gpioPrev_q <= gpioIn;
        end
    end

    assign protectCodeSelect = sel_q;
    assign protectSlewActive = slew_q;
    assign protectHiz        = hiz_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Any accepted write, host or PMBus, after command mapping
    logic accWr;
    assign accWr = req.write && !refused && mapped;

    sequence s_nvm_then_hiz;
        protectCodeSelect == DCR_ACT_NVM && !protectHiz ##1 protectHiz;
    endsequence

    chk_low_power_set: assert property (accWr &&
        req.addr == DCR_ADDR_DEVICE_MODE |=>
        lowPowerMode == $past(req.data[DCR_BIT_MODE_IN_DIS]))
        else $error("low power bit not taken from write");
    chk_protect_direct_hiz: assert property (prot_q == PR_IDLE &&
        protectFall && action == DCR_ACT_HIZ |=> protectHiz && !slew_q)
        else $error("direct Hi-Z action late");
    chk_protect_nvm_step: assert property (prot_q == PR_IDLE &&
        protectFall && action == DCR_ACT_NVM |=> s_nvm_then_hiz)
        else $error("NVM jump sequence wrong");
    chk_protect_slew_start: assert property (prot_q == PR_IDLE &&
        protectFall && action[1] |=> protectSlewActive throughout
        (!slewDone [*1] ##0 1'b1))
        else $error("slew not started");
    chk_rise_ignored: assert property (prot_q == PR_IDLE &&
        !gpioPrev_q && gpioIn |=> prot_q == PR_IDLE)
        else $error("rising pin started protect");
    chk_pmbus_gated: assert property (!pmbusEnable &&
        !hostReq.write && !hostReq.read &&
        (pmbusReq.write || pmbusReq.read) |=>
        respValid && respError && $stable(page_q))
        else $error("PMBus access taken while disabled");
    chk_sram_advance: assert property (accWr &&
        req.addr == DCR_ADDR_SRAM_WORD |=>
        sramPtr_q == 8'($past(sramPtr_q) + 8'h01))
        else $error("pointer did not advance");
    chk_sram_readback: assert property (accWr &&
        req.addr == DCR_ADDR_SRAM_WORD |=>
        sram_q[$past(sramPtr_q)] == $past(req.data))
        else $error("memory word not stored");
    // Back-to-back broadcast writes are legal, so the idle case is separate
    chk_broadcast_gate: assert property (accWr &&
        req.addr == DCR_ADDR_BROADCAST |=>
        channelCodeLoad == $past(channelBroadcastEnable))
        else $error("broadcast load mismatch");
    chk_broadcast_idle: assert property (!(accWr &&
        req.addr == DCR_ADDR_BROADCAST) |=> channelCodeLoad == '0)
        else $error("channel load without broadcast write");
    chk_ignored_bits_zero: assert property (respValid &&
        !respError |-> (devMode_q & ~DCR_MASK_DEVICE_MODE) == 16'h0000)
        else $error("ignored bits held a value");
endmodule

//--- dcr_dac_model.sv
// Stand-in for the DAC core: answers slews and latches broadcast codes
module dcr_dac_model
    import dcr_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // From the configuration group
    input  wire logic                     protectSlewActive,
    input  wire logic [DCR_CHANNELS-1:0]  channelCodeLoad,
    input  wire logic [DCR_CODE_BITS-1:0] allChannelCodeValue,
    // Back to the configuration group
    output logic                          slewDone
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned              slewDelay = 3;
    int unsigned              slewCount = 0;
    logic [DCR_CODE_BITS-1:0] chanCode [DCR_CHANNELS];

    initial slewDone = 1'b0;

    // Done is a one-cycle pulse; a slow core just raises the delay
    always @(negedge clk) begin
        if (reset || !protectSlewActive) begin
            slewCount = 0;
            slewDone <= 1'b0;
        end else begin
            slewCount = slewCount + 1;
            slewDone <= (slewCount == slewDelay);
        end
    end

    // Only channels named in the load pulse take the code
    always @(posedge clk) begin
        for (int i = 0; i < DCR_CHANNELS; i++) begin
            if (reset) begin
                chanCode[i] <= '0;
            end else if (channelCodeLoad[i]) begin
                chanCode[i] <= allChannelCodeValue;
            end
        end
    end
endmodule

//--- dcr_config_regs_tb_top.sv
// Self-checking bench for the DAC configuration register group
module dcr_config_regs_tb_top
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk;
    logic                     reset;
    dcr_req_t                 hostReq;
    dcr_req_t                 pmbusReq;
    logic                     respValid;
    logic                     respError;
    logic [15:0]              respData;
    logic                     gpioIn;
    logic                     gpioInputEnable;
    logic [3:0]               gpioInputConfig;
    logic [DCR_CHANNELS-1:0]  channelBroadcastEnable;
    logic                     slewDone;
    logic                     protectClear;
    logic [DCR_CHANNELS-1:0]  channelCodeLoad;
    logic [DCR_CODE_BITS-1:0] allChannelCodeValue;
    dcr_action_t              protectCodeSelect;
    logic                     protectSlewActive;
    logic                     protectHiz;
    logic                     lowPowerMode;
    logic                     pmbusEnable;
    logic                     serialReadoutEnable;
    int                       n_errors = 0;
    int                       comparisons = 0;

    dcr_config_regs u_dut (.clk(clk), .reset(reset), .hostReq(hostReq),
        .pmbusReq(pmbusReq), .respValid(respValid), .respError(respError),
        .respData(respData), .gpioIn(gpioIn),
        .gpioInputEnable(gpioInputEnable), .gpioInputConfig(gpioInputConfig),
        .channelBroadcastEnable(channelBroadcastEnable), .slewDone(slewDone),
        .protectClear(protectClear), .channelCodeLoad(channelCodeLoad),
        .allChannelCodeValue(allChannelCodeValue),
        .protectCodeSelect(protectCodeSelect),
        .protectSlewActive(protectSlewActive), .protectHiz(protectHiz),
        .lowPowerMode(lowPowerMode), .pmbusEnable(pmbusEnable),
        .serialReadoutEnable(serialReadoutEnable));

    dcr_dac_model u_dac (.clk(clk), .reset(reset),
        .protectSlewActive(protectSlewActive),
        .channelCodeLoad(channelCodeLoad),
        .allChannelCodeValue(allChannelCodeValue), .slewDone(slewDone));

    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One access; the answer stands in the cycle after the taking edge
    task automatic access(input logic pm, input logic wr, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] rd, output logic err);
        dcr_req_t r;
        r = '{write: wr, read: !wr, addr: a, data: d};
        @(negedge clk);
        if (pm) begin
            pmbusReq = r;
        end else begin
            hostReq = r;
        end
        @(negedge clk);
        hostReq = '0;
        pmbusReq = '0;
        check({15'h0, respValid}, 16'h0001);
        rd = respData;
        err = respError;
    endtask

    task automatic wr(input logic pm, input logic [7:0] a,
        input logic [15:0] d);
        logic [15:0] rd;
        logic        err;
        access(pm, 1'b1, a, d, rd, err);
        check({15'h0, err}, 16'h0000);
    endtask

    task automatic rdchk(input logic pm, input logic [7:0] a,
        input logic [15:0] exp, input logic expErr);
        logic [15:0] rd;
        logic        err;
        access(pm, 1'b0, a, 16'h0000, rd, err);
        check({15'h0, err}, {15'h0, expErr});
        check(rd, exp);
    endtask

    // Falling edge on the protect input, wait for Hi-Z, then clear
    task automatic protect(input logic [1:0] act);
        int n;
        int lo;
        int hi;
        n = 0;
        lo = (act == 2'h0) ? 0 : (act == 2'h1) ? 1 : int'(u_dac.slewDelay);
        hi = act[1] ? lo + 1 : lo;
        wr(1'b0, DCR_ADDR_DEVICE_MODE, {6'h00, act, 8'h00});
        @(negedge clk);
        gpioIn = 1'b0;
        @(negedge clk);
        check({14'h0, protectCodeSelect}, {14'h0, act});
        check({15'h0, protectSlewActive}, {15'h0, act[1]});
        while (protectHiz !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, (n >= lo && n <= hi)}, 16'h0001);
        gpioIn = 1'b1;
        repeat (2) @(negedge clk);
        check({15'h0, protectHiz}, 16'h0001);
        protectClear = 1'b1;
        @(negedge clk);
        protectClear = 1'b0;
        check({13'h0, protectHiz, protectCodeSelect}, 16'h0000);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        hostReq = '0;
        pmbusReq = '0;
        gpioIn = 1'b1;
        gpioInputEnable = 1'b1;
        gpioInputConfig = DCR_GPI_PROTECT;
        channelBroadcastEnable = 2'b10;
        protectClear = 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rdchk(1'b0, DCR_ADDR_DEVICE_MODE, 16'h0000, 1'b0);
        rdchk(1'b0, DCR_ADDR_INTERFACE, 16'h0000, 1'b0);
        rdchk(1'b0, DCR_ADDR_SRAM_POINTER, 16'h0000, 1'b0);
        rdchk(1'b0, DCR_ADDR_BROADCAST, 16'h0000, 1'b0);
        rdchk(1'b0, 8'h00, 16'h0000, 1'b1);
        rdchk(1'b1, DCR_PM_CMD_PAGE, 16'h0000, 1'b1);
        wr(1'b0, DCR_ADDR_INTERFACE, 16'hffff);
        rdchk(1'b0, DCR_ADDR_INTERFACE, 16'h1105, 1'b0);
        check({14'h0, pmbusEnable, serialReadoutEnable}, 16'h0003);
        rdchk(1'b1, DCR_PM_CMD_PAGE, 16'h0300, 1'b0);
        rdchk(1'b1, DCR_PM_CMD_SRAM_PTR, 16'h0000, 1'b1);
        wr(1'b1, DCR_PM_CMD_PAGE, 16'hffff);
        rdchk(1'b1, DCR_PM_CMD_PAGE, 16'hff00, 1'b0);
        wr(1'b1, DCR_PM_CMD_DEVICE, 16'h2000);
        rdchk(1'b0, DCR_ADDR_DEVICE_MODE, 16'h2000, 1'b0);
        check({15'h0, lowPowerMode}, 16'h0001);
        wr(1'b0, DCR_ADDR_DEVICE_MODE, 16'h0000);
        check({15'h0, lowPowerMode}, 16'h0000);
        wr(1'b1, DCR_PM_CMD_SRAM_PTR, 16'hfffe);
        rdchk(1'b0, DCR_ADDR_SRAM_POINTER, 16'h00fe, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(1'b1, DCR_PM_CMD_SRAM_WORD, 16'(16'h1000 + i));
        end
        rdchk(1'b0, DCR_ADDR_SRAM_POINTER, 16'h0001, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, DCR_ADDR_SRAM_POINTER, {8'h00, 8'(8'hfe + i)});
            rdchk(1'b0, DCR_ADDR_SRAM_WORD, 16'(16'h1000 + i), 1'b0);
            rdchk(1'b1, DCR_PM_CMD_SRAM_WORD, 16'(16'h1000 + i), 1'b0);
        end
        wr(1'b1, DCR_PM_CMD_BROADCAST, 16'habcd);
        check({14'h0, channelCodeLoad}, 16'h0002);
        check({4'h0, allChannelCodeValue}, 16'h0abc);
        rdchk(1'b0, DCR_ADDR_BROADCAST, 16'habc0, 1'b0);
        channelBroadcastEnable = 2'b01;
        wr(1'b0, DCR_ADDR_BROADCAST, 16'h123f);
        check({14'h0, channelCodeLoad}, 16'h0001);
        @(negedge clk);
        check({4'h0, u_dac.chanCode[0]}, 16'h0123);
        check({4'h0, u_dac.chanCode[1]}, 16'h0abc);
        gpioInputConfig = 4'h2;
        gpioIn = 1'b0;
        repeat (3) @(negedge clk);
        check({15'h0, protectHiz}, 16'h0000);
        gpioIn = 1'b1;
        gpioInputConfig = DCR_GPI_PROTECT;
        for (int a = 0; a < 4; a++) begin
            protect(2'(a));
        end
        u_dac.slewDelay = 8;
        protect(2'h2);
        wr(1'b0, DCR_ADDR_INTERFACE, 16'h1004);
        check({14'h0, pmbusEnable, serialReadoutEnable}, 16'h0000);
        rdchk(1'b1, DCR_PM_CMD_BROADCAST, 16'h0000, 1'b1);
        close_out();
    end
endmodule
